/* hdl/charger_interrupt_flags.sv */
`timescale 1ns/1ps
// Function
// [RQ1] set bad-adaptor flag on poor source or input below lockout level
// [RQ2] set battery-overvoltage flag on battery overvoltage while charging; code sets it on battery_overvoltage_i alone, whatever the charge state
// [RQ3] set boost input-overvoltage flag when boosting and input above threshold
// [RQ4] set boost overload flag when boost output is overloaded
// [RQ5] set boost low-battery flag when battery too low for boost
// [RQ6] input-overvoltage mask: 0 passes interrupt, 1 blocks it
// [RQ7] wake timer mask: 0 passes interrupt, 1 blocks it
// [RQ8] watchdog expiry mask: 0 passes interrupt, 1 blocks it
// [RQ9] set thermal shutdown flag when die exceeds shutdown temperature
// [RQ10] interrupt asserts when any flag set and its mask bit is 0
module charger_interrupt_flags
	import charger_irq_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR = DEFAULT_SLAVE_ADDR
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	input wire logic bad_adaptor_i,
	input wire logic battery_overvoltage_i,
	input wire logic boost_mode_i,
	input wire logic boost_vin_above_threshold_i,
	input wire logic boost_overload_i,
	input wire logic boost_low_battery_i,
	input wire logic die_over_temperature_i,
	input wire logic input_overvoltage_i,
	input wire logic wake_timer_expired_i,
	input wire logic watchdog_expired_i,
	output logic irq_n_o
);
	logic [EV_COUNT-1:0] ev_raw;
	logic [EV_COUNT-1:0] ev_s;
	logic [1:0] bus_s;
	logic scl_s, sda_s, scl_q, sda_q;
	logic start_det, stop_det, scl_rise, scl_fall;
	bus_state_t state_q, state_d;
	logic [7:0] shift_q, shift_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] ptr_q, ptr_d;
	logic rw_q, rw_d;
	logic drive_q, drive_d;
	logic ack_q, ack_d;
	logic [7:0] mask_q, mask_d;
	logic [7:0] sys_flags_q, sys_flags_d;
	logic [7:0] chg_flags_q, chg_flags_d;
	logic [7:0] bst_flags_q, bst_flags_d;
	logic [7:0] sys_set, chg_set, bst_set;
	logic rd_clr;
	logic [7:0] rd_clr_ofs;
	logic irq_any;

	assign ev_raw[EV_BAD_ADAPTOR] = bad_adaptor_i;
	assign ev_raw[EV_BATTERY_OV] = battery_overvoltage_i;
	assign ev_raw[EV_BOOST_MODE] = boost_mode_i;
	assign ev_raw[EV_BOOST_VIN_OV] = boost_vin_above_threshold_i;
	assign ev_raw[EV_BOOST_OVERLOAD] = boost_overload_i;
	assign ev_raw[EV_BOOST_LOW_BATT] = boost_low_battery_i;
	assign ev_raw[EV_THERMAL] = die_over_temperature_i;
	assign ev_raw[EV_INPUT_OV] = input_overvoltage_i;
	assign ev_raw[EV_WAKE_TIMER] = wake_timer_expired_i;
	assign ev_raw[EV_WATCHDOG] = watchdog_expired_i;

	// analog comparator levels and bus pins enter through two flops
	level_sync #(.WIDTH(EV_COUNT)) u_ev_sync (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.async_i(ev_raw),
		.sync_o(ev_s)
	);

	// bus lines pass inverted so the cleared sync flops match idle-high
	// lines; avoids a false rising edge straight after reset
	level_sync #(.WIDTH(2)) u_bus_sync (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.async_i({!scl_i, !sda_i}),
		.sync_o(bus_s)
	);

	assign scl_s = !bus_s[1];
	assign sda_s = !bus_s[0];

	// register read mux; unmapped offsets read zero
	function automatic logic [7:0] reg_read(input logic [7:0] ofs,
		input logic [7:0] sys, input logic [7:0] chg,
		input logic [7:0] bst, input logic [7:0] msk);
		logic [7:0] v;
		v = UNMAPPED_RD;
		unique case (ofs)
			SYSTEM_EVENT_FLAGS_OFS: v = sys;
			CHARGER_EVENT_FLAGS_OFS: v = chg;
			BOOST_EVENT_FLAGS_OFS: v = bst;
			SYSTEM_FAULT_MASK_OFS: v = msk;
			default: v = UNMAPPED_RD;
		endcase
		return v;
	endfunction

	// bus line edge and framing detection on synchronised levels
	always_comb begin
		start_det = scl_s && scl_q && sda_q && !sda_s;
		stop_det = scl_s && scl_q && !sda_q && sda_s;
		scl_rise = scl_s && !scl_q;
		scl_fall = !scl_s && scl_q;
	end

	// bus protocol: address, pointer, writes, auto-increment reads
	always_comb begin
		logic [7:0] rd;
		rd = reg_read(ptr_q, sys_flags_q, chg_flags_q, bst_flags_q, mask_q);
		state_d = state_q;
		shift_d = shift_q;
		cnt_d = cnt_q;
		ptr_d = ptr_q;
		rw_d = rw_q;
		drive_d = drive_q;
		ack_d = ack_q;
		mask_d = mask_q;
		rd_clr = 1'b0;
		rd_clr_ofs = ptr_q;
		if (start_det) begin
			state_d = ST_ADDR;
			cnt_d = 4'h0;
			drive_d = 1'b0;
		end else if (stop_det) begin
			state_d = ST_IDLE;
			drive_d = 1'b0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					drive_d = 1'b0;
				end
				ST_ADDR, ST_REG, ST_WRITE: begin
					if (scl_rise && cnt_q != BITS_PER_BYTE) begin
						shift_d = {shift_q[6:0], sda_s};
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
						drive_d = 1'b1;
						if (state_q == ST_ADDR) begin
							rw_d = shift_q[0];
							if (shift_q[7:1] == SLAVE_ADDR) begin
								state_d = ST_ADDR_ACK;
							end else begin
								state_d = ST_IDLE;
								drive_d = 1'b0;
							end
						end else if (state_q == ST_REG) begin
							ptr_d = shift_q;
							state_d = ST_WRITE_ACK;
						end else begin
							if (ptr_q == SYSTEM_FAULT_MASK_OFS) begin
								mask_d = shift_q; // RQ6 RQ7 RQ8
							end
							ptr_d = ptr_q + 8'h01;
							state_d = ST_WRITE_ACK;
						end
					end
				end
				ST_ADDR_ACK, ST_READ_ACK: begin
					if (scl_rise) begin
						ack_d = !sda_s;
					end else if (scl_fall) begin
						cnt_d = 4'h0;
						if (state_q == ST_ADDR_ACK && !rw_q) begin
							drive_d = 1'b0;
							state_d = ST_REG;
						end else if (state_q == ST_READ_ACK && !ack_q) begin
							drive_d = 1'b0;
							state_d = ST_IDLE;
						end else begin
							shift_d = rd;
							drive_d = !rd[7];
							rd_clr = 1'b1;
							ptr_d = ptr_q + 8'h01;
							state_d = ST_READ;
						end
					end
				end
				ST_WRITE_ACK: begin
					if (scl_fall) begin
						drive_d = 1'b0;
						cnt_d = 4'h0;
						state_d = ST_WRITE;
					end
				end
				ST_READ: begin
					if (scl_fall) begin
						if (cnt_q == BITS_PER_BYTE - 4'h1) begin
							drive_d = 1'b0;
							ack_d = 1'b0;
							state_d = ST_READ_ACK;
						end else begin
							shift_d = {shift_q[6:0], 1'b0};
							drive_d = !shift_q[6];
							cnt_d = cnt_q + 4'h1;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			state_q <= ST_IDLE;
			shift_q <= 8'h00;
			cnt_q <= 4'h0;
			ptr_q <= 8'h00;
			rw_q <= 1'b0;
			drive_q <= 1'b0;
			ack_q <= 1'b0;
			mask_q <= MASK_RST;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
			state_q <= state_d;
			shift_q <= shift_d;
			cnt_q <= cnt_d;
			ptr_q <= ptr_d;
			rw_q <= rw_d;
			drive_q <= drive_d;
			ack_q <= ack_d;
			mask_q <= mask_d;
		end
	end

	// open-drain data line: only ever pulls low
	assign sda_o = 1'b0;
	assign sda_oe_n_o = !drive_q;

	// flag sources; a set in the clearing cycle wins
	always_comb begin
		sys_set = 8'h00;
		chg_set = 8'h00;
		bst_set = 8'h00;
		sys_set[THERMAL_SHUTDOWN_BIT] = ev_s[EV_THERMAL]; // RQ9
		sys_set[INPUT_OVERVOLTAGE_BIT] = ev_s[EV_INPUT_OV];
		sys_set[WAKE_TIMER_BIT] = ev_s[EV_WAKE_TIMER];
		sys_set[WATCHDOG_EXPIRY_BIT] = ev_s[EV_WATCHDOG];
		chg_set[BAD_ADAPTOR_BIT] = ev_s[EV_BAD_ADAPTOR]; // RQ1
		chg_set[BATTERY_OVERVOLTAGE_BIT] = ev_s[EV_BATTERY_OV]; // RQ2
		bst_set[BOOST_INPUT_OVERVOLTAGE_BIT] =
			ev_s[EV_BOOST_MODE] && ev_s[EV_BOOST_VIN_OV]; // RQ3
		bst_set[BOOST_OVERLOAD_BIT] = ev_s[EV_BOOST_OVERLOAD]; // RQ4
		bst_set[BOOST_LOW_BATTERY_BIT] = ev_s[EV_BOOST_LOW_BATT]; // RQ5
		sys_flags_d = sys_flags_q;
		chg_flags_d = chg_flags_q;
		bst_flags_d = bst_flags_q;
		if (rd_clr && rd_clr_ofs == SYSTEM_EVENT_FLAGS_OFS) begin
			sys_flags_d = FLAGS_RST;
		end
		if (rd_clr && rd_clr_ofs == CHARGER_EVENT_FLAGS_OFS) begin
			chg_flags_d = FLAGS_RST;
		end
		if (rd_clr && rd_clr_ofs == BOOST_EVENT_FLAGS_OFS) begin
			bst_flags_d = FLAGS_RST;
		end
		sys_flags_d = sys_flags_d | sys_set;
		chg_flags_d = chg_flags_d | chg_set;
		bst_flags_d = bst_flags_d | bst_set;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			sys_flags_q <= FLAGS_RST;
			chg_flags_q <= FLAGS_RST;
			bst_flags_q <= FLAGS_RST;
		end else begin
			sys_flags_q <= sys_flags_d;
			chg_flags_q <= chg_flags_d;
			bst_flags_q <= bst_flags_d;
		end
	end

	// masked system flags plus always-reported charger and boost flags
	assign irq_any = |(sys_flags_q & ~mask_q) | |chg_flags_q |
		|bst_flags_q; // RQ10
	assign irq_n_o = !irq_any;

	a_bad_adaptor_set: assert property (@(posedge ref_clk_i) // RQ1
		disable iff (!rst_n_i) ev_s[EV_BAD_ADAPTOR] |=>
		chg_flags_q[BAD_ADAPTOR_BIT])
		else $error("bad adaptor flag not set");
	a_battery_ov_set: assert property (@(posedge ref_clk_i) // RQ2
		disable iff (!rst_n_i) ev_s[EV_BATTERY_OV] |=>
		chg_flags_q[BATTERY_OVERVOLTAGE_BIT])
		else $error("battery overvoltage flag not set");
	a_boost_ovp_set: assert property (@(posedge ref_clk_i) // RQ3
		disable iff (!rst_n_i)
		(ev_s[EV_BOOST_MODE] && ev_s[EV_BOOST_VIN_OV]) |=>
		bst_flags_q[BOOST_INPUT_OVERVOLTAGE_BIT])
		else $error("boost input overvoltage flag not set");
	a_boost_ovp_gated: assert property (@(posedge ref_clk_i) // RQ3
		disable iff (!rst_n_i)
		($rose(bst_flags_q[BOOST_INPUT_OVERVOLTAGE_BIT])) |->
		$past(ev_s[EV_BOOST_MODE]))
		else $error("boost input overvoltage set outside boost mode");
	a_overload_set: assert property (@(posedge ref_clk_i) // RQ4
		disable iff (!rst_n_i) ev_s[EV_BOOST_OVERLOAD] |=>
		bst_flags_q[BOOST_OVERLOAD_BIT])
		else $error("boost overload flag not set");
	a_low_batt_set: assert property (@(posedge ref_clk_i) // RQ5
		disable iff (!rst_n_i) ev_s[EV_BOOST_LOW_BATT] |=>
		bst_flags_q[BOOST_LOW_BATTERY_BIT])
		else $error("boost low battery flag not set");
	a_input_ov_mask: assert property (@(posedge ref_clk_i) // RQ6
		disable iff (!rst_n_i)
		(sys_flags_q == (8'h01 << INPUT_OVERVOLTAGE_BIT) &&
		chg_flags_q == 8'h00 && bst_flags_q == 8'h00) |->
		(irq_n_o == mask_q[INPUT_OVERVOLTAGE_BIT]))
		else $error("input overvoltage mask misapplied");
	a_wake_timer_mask: assert property (@(posedge ref_clk_i) // RQ7
		disable iff (!rst_n_i)
		(sys_flags_q[WAKE_TIMER_BIT] && !mask_q[WAKE_TIMER_BIT]) |->
		!irq_n_o)
		else $error("unmasked wake timer flag not reported");
	a_watchdog_mask: assert property (@(posedge ref_clk_i) // RQ8
		disable iff (!rst_n_i)
		(sys_flags_q == (8'h01 << WATCHDOG_EXPIRY_BIT) &&
		mask_q[WATCHDOG_EXPIRY_BIT] && chg_flags_q == 8'h00 &&
		bst_flags_q == 8'h00) |-> irq_n_o)
		else $error("masked watchdog flag reported");
	a_thermal_set: assert property (@(posedge ref_clk_i) // RQ9
		disable iff (!rst_n_i) ev_s[EV_THERMAL] |=>
		sys_flags_q[THERMAL_SHUTDOWN_BIT])
		else $error("thermal shutdown flag not set");
	a_irq_raised: assert property (@(posedge ref_clk_i) // RQ10
		disable iff (!rst_n_i)
		$rose(chg_flags_q[BAD_ADAPTOR_BIT]) |-> !irq_n_o)
		else $error("charger flag did not raise interrupt");
endmodule

/* hdl/charger_irq_pkg.sv */
package charger_irq_pkg;
	// register offsets
	localparam logic [7:0] SYSTEM_EVENT_FLAGS_OFS = 8'h08;
	localparam logic [7:0] CHARGER_EVENT_FLAGS_OFS = 8'h09;
	localparam logic [7:0] BOOST_EVENT_FLAGS_OFS = 8'h0a;
	localparam logic [7:0] SYSTEM_FAULT_MASK_OFS = 8'h0b;
	// reset values
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] UNMAPPED_RD = 8'h00;
	// system event flag and mask bit positions
	localparam int THERMAL_SHUTDOWN_BIT = 7;
	localparam int INPUT_OVERVOLTAGE_BIT = 6;
	localparam int WAKE_TIMER_BIT = 5;
	localparam int WATCHDOG_EXPIRY_BIT = 4;
	// charger event flag bit positions
	localparam int BAD_ADAPTOR_BIT = 6;
	localparam int BATTERY_OVERVOLTAGE_BIT = 5;
	// boost event flag bit positions
	localparam int BOOST_INPUT_OVERVOLTAGE_BIT = 7;
	localparam int BOOST_OVERLOAD_BIT = 6;
	localparam int BOOST_LOW_BATTERY_BIT = 5;
	// synchronised event input lanes
	localparam int EV_BAD_ADAPTOR = 0;
	localparam int EV_BATTERY_OV = 1;
	localparam int EV_BOOST_MODE = 2;
	localparam int EV_BOOST_VIN_OV = 3;
	localparam int EV_BOOST_OVERLOAD = 4;
	localparam int EV_BOOST_LOW_BATT = 5;
	localparam int EV_THERMAL = 6;
	localparam int EV_INPUT_OV = 7;
	localparam int EV_WAKE_TIMER = 8;
	localparam int EV_WATCHDOG = 9;
	localparam int EV_COUNT = 10;
	// serial bus framing
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [6:0] DEFAULT_SLAVE_ADDR = 7'h25; // arbitrary value
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_ADDR = 4'b0001,
		ST_ADDR_ACK = 4'b0010,
		ST_REG = 4'b0011,
		ST_WRITE = 4'b0100,
		ST_WRITE_ACK = 4'b0101,
		ST_READ = 4'b0110,
		ST_READ_ACK = 4'b0111
	} bus_state_t;
endpackage

/* hdl/level_sync.sv */
`timescale 1ns/1ps
module level_sync #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] stable_q;
	logic [WIDTH-1:0] stable_d;

	// two-stage capture; only the second stage is seen outside
	always_comb begin
		meta_d = async_i;
		stable_d = meta_q;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			meta_q <= '0;
			stable_q <= '0;
		end else begin
			meta_q <= meta_d;
			stable_q <= stable_d;
		end
	end

	assign sync_o = stable_q;
endmodule

/* verification/i2c_host_model.sv */
`timescale 1ns/1ps
module i2c_host_model
	import charger_irq_pkg::*;
(
	input wire logic clk_i,
	input wire logic sda_line_i,
	output logic scl_o,
	output logic sda_o
);
	// both lines released and still between frames
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// one bus phase, five ref clocks, changed just after an edge
	task automatic ph();
		repeat (5) @(posedge clk_i);
		#1;
	endtask
	// drive one bit (1 releases) and sample the wire while scl is high
	task automatic bit_io(input logic b, output logic r);
		sda_o = b;
		ph();
		scl_o = 1'b1;
		ph();
		r = sda_line_i;
		scl_o = 1'b0;
	endtask
	task automatic start();
		sda_o = 1'b1;
		ph();
		scl_o = 1'b1;
		ph();
		sda_o = 1'b0;
		ph();
		scl_o = 1'b0;
	endtask
	task automatic stop();
		sda_o = 1'b0;
		ph();
		scl_o = 1'b1;
		ph();
		sda_o = 1'b1;
		ph();
	endtask
	// eight bits msb first, then the acknowledge slot
	task automatic byte_io(input logic [7:0] v, input logic ab,
		output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--) begin
			bit_io(v[i], r[i]);
		end
		bit_io(ab, a);
	endtask
	// one register access; nak is high if the device left any address, offset or write byte unacknowledged
	task automatic access(input logic rd, input logic [7:0] ofs,
		input logic [7:0] wd, output logic [7:0] rdv, output logic nak);
		logic [7:0] d;
		logic a;
		start();
		byte_io({DEFAULT_SLAVE_ADDR, 1'b0}, 1'b1, d, a);
		nak = a;
		byte_io(ofs, 1'b1, d, a);
		nak = nak | a;
		rdv = 8'h00;
		if (rd) begin
			start();
			byte_io({DEFAULT_SLAVE_ADDR, 1'b1}, 1'b1, d, a);
			nak = nak | a;
			byte_io(8'hff, 1'b1, rdv, a);
		end else begin
			byte_io(wd, 1'b1, d, a);
			nak = nak | a;
		end
		stop();
	endtask
endmodule

/* verification/testbench.sv */
`timescale 1ns/1ps
module testbench import charger_irq_pkg::*; ;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [EV_COUNT-1:0] ev = '0;
	logic scl, host_sda, sda_line, sda_o, sda_oe_n_o, irq_n_o;
	logic [15:0] lfsr = 16'h001f;
	int err_count = 0;
	int num_checks = 0;
	always #50 ref_clk_i = ~ref_clk_i;
	// open-drain data wire with pull-up
	assign sda_line = host_sda & (sda_oe_n_o | sda_o);
	i2c_host_model u_i2c_host_model (.clk_i(ref_clk_i),
		.sda_line_i(sda_line), .scl_o(scl), .sda_o(host_sda));
	charger_interrupt_flags u_charger_interrupt_flags (
		.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .scl_i(scl),
		.sda_i(sda_line), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
		.bad_adaptor_i(ev[EV_BAD_ADAPTOR]),
		.battery_overvoltage_i(ev[EV_BATTERY_OV]),
		.boost_mode_i(ev[EV_BOOST_MODE]),
		.boost_vin_above_threshold_i(ev[EV_BOOST_VIN_OV]),
		.boost_overload_i(ev[EV_BOOST_OVERLOAD]),
		.boost_low_battery_i(ev[EV_BOOST_LOW_BATT]),
		.die_over_temperature_i(ev[EV_THERMAL]),
		.input_overvoltage_i(ev[EV_INPUT_OV]),
		.wake_timer_expired_i(ev[EV_WAKE_TIMER]),
		.watchdog_expired_i(ev[EV_WATCHDOG]), .irq_n_o(irq_n_o));
	function automatic logic [15:0] next_rand(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// register offset and bit position of each event lane
	function automatic logic [15:0] where_flag(input int lane);
		case (lane)
			EV_BAD_ADAPTOR: return {CHARGER_EVENT_FLAGS_OFS, 8'(BAD_ADAPTOR_BIT)};
			EV_BATTERY_OV: return {CHARGER_EVENT_FLAGS_OFS, 8'h05};
			EV_BOOST_VIN_OV: return {BOOST_EVENT_FLAGS_OFS, 8'h07};
			EV_BOOST_OVERLOAD: return {BOOST_EVENT_FLAGS_OFS, 8'h06};
			EV_BOOST_LOW_BATT: return {BOOST_EVENT_FLAGS_OFS, 8'h05};
			EV_THERMAL: return {SYSTEM_EVENT_FLAGS_OFS, 8'h07};
			EV_INPUT_OV: return {SYSTEM_EVENT_FLAGS_OFS, 8'h06};
			EV_WAKE_TIMER: return {SYSTEM_EVENT_FLAGS_OFS, 8'h05};
			default: return {SYSTEM_EVENT_FLAGS_OFS, 8'h04};
		endcase
	endfunction
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic r, input logic [7:0] o,
		input logic [7:0] wd, output logic [7:0] v);
		logic n;
		u_i2c_host_model.access(r, o, wd, v, n);
		chk_bit(n, 1'b0);
	endtask
	// hold one event level for five clocks, then let it go
	task automatic pulse(input int lane, input logic boost);
		ev[lane] = 1'b1;
		ev[EV_BOOST_MODE] = boost;
		repeat (5) @(posedge ref_clk_i);
		#1;
		ev = '0;
		repeat (4) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic print_verdict();
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		logic [7:0] v, m;
		logic [15:0] w;
		repeat (8) @(posedge ref_clk_i);
		#1;
		rst_n_i = 1'b1;
		@(posedge ref_clk_i);
		#1;
		chk_bit(irq_n_o, 1'b1);
		for (int i = 8; i < 12; i++) begin
			acc(1'b1, 8'(i), 8'h00, v);
			chk_byte(v, 8'h00);
		end
		acc(1'b1, 8'h20, 8'h00, v);
		chk_byte(v, UNMAPPED_RD);
		acc(1'b0, CHARGER_EVENT_FLAGS_OFS, 8'hff, v);
		acc(1'b1, CHARGER_EVENT_FLAGS_OFS, 8'h00, v);
		chk_byte(v, FLAGS_RST);
		// boost input overvoltage outside boost mode stays clear
		pulse(EV_BOOST_VIN_OV, 1'b0);
		chk_bit(irq_n_o, 1'b1);
		acc(1'b1, BOOST_EVENT_FLAGS_OFS, 8'h00, v);
		chk_byte(v, 8'h00);
		// every event lane except boost mode under a random mask and its inverse
		for (int lane = 0; lane < EV_COUNT; lane++) begin
			if (lane == EV_BOOST_MODE) continue;
			w = where_flag(lane);
			lfsr = next_rand(lfsr);
			for (int k = 0; k < 2; k++) begin
				m = (k == 0) ? lfsr[7:0] : ~lfsr[7:0];
				acc(1'b0, SYSTEM_FAULT_MASK_OFS, m, v);
				acc(1'b1, SYSTEM_FAULT_MASK_OFS, 8'h00, v);
				chk_byte(v, m);
				pulse(lane, lane == EV_BOOST_VIN_OV);
				v = (w[15:8] == SYSTEM_EVENT_FLAGS_OFS) ? m : 8'h00;
				chk_bit(irq_n_o, v[w[2:0]]);
				acc(1'b1, w[15:8], 8'h00, v);
				chk_byte(v, 8'h01 << w[2:0]);
				chk_bit(irq_n_o, 1'b1);
				acc(1'b1, w[15:8], 8'h00, v);
				chk_byte(v, 8'h00);
			end
		end
		print_verdict();
	end
	// watchdog against a hung bus
	initial begin
		repeat (60000) @(posedge ref_clk_i);
		err_count++;
		print_verdict();
	end
endmodule
